// ### core/ssmc_sensor.sv
// Sensor end: serial register file, power state and sequencer model.
// Assumes the link pins are synchronous to I_CLK and sclk half
// periods last at least two I_CLK cycles.
//
// What this block and the host end do
// - Clearing mode bit 0 stops sequencer, idle.
// - Host keeps other mode bits when disabling.
// - Host soft power-down writes in fixed order.
// - Power-down writes disable blocks, enter standby.
// - Zero to address 34 halts logic clocking.
// - Mode bit 1 selects global or rolling.
// - Mode bits 3:2 select normal or zero overhead.
// - Mode bit 4 triggered, global shutter only.
// - Mode bit 5 slave, global shutter only.
// - Mode bits 7, 8 enable subsampling, binning.
// - Host alters mode fields only when stopped or by a start order.
// - Window registers writable in every live state.
// - Reset leaves only window zero active.
// - Exposure and gain writable in live states.
// - Host changes static registers other than mode only when stopped.
// - Host keeps reserved registers at defaults.
// - Black-level rewrite gives transient, then applies.
// - Sync-code rewrite spoils only current frame.
// - Test-pattern rewrite spoils one frame.
// - Artifact-prone writes never halt acquisition.
// - Mode 0x0001 or 0x000D starts acquisition.
// - Idle keeps clocks and blocks, sequencer off.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module ssmc_sensor #(
   parameter int REG_COUNT = 512,
   parameter int FRAME_CYCLES = 1024
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // Serial register link
   ssmc_link_if.sensor link,
   // Power and acquisition state
   output ssmc_pkg::ssmc_pwr_t O_STATE,
   output logic O_CLOCKS_ON,
   output logic O_BLOCKS_ON,
   output logic O_ACQUIRING,
   output logic O_FRAME_START,
   output logic O_ARTIFACT,
   // Active mode fields
   output logic O_ROLLING,
   output logic [1:0] O_ROT_MODE,
   output logic O_TRIGGERED,
   output logic O_SLAVE,
   output logic O_SUBSAMPLE,
   output logic O_BINNING,
   // Active window set and gain
   output logic [31:0] O_WIN_ACTIVE,
   output logic [15:0] O_GAIN
);
   import ssmc_pkg::*;

   localparam int FW = $clog2(FRAME_CYCLES);

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (REG_COUNT <= int'(A_WIN_LAST) || REG_COUNT > 2 ** ADDR_W)
   begin : g_bad_regs
      $error("REG_COUNT must cover the window area and fit the address");
   end
   if (FRAME_CYCLES < 2)
   begin : g_bad_frame
      $error("FRAME_CYCLES must be at least 2");
   end

   // Reset value of one register
   function automatic logic [DATA_W-1:0] reg_reset(input int i);
      return (i == int'(A_WIN_ACT_LO)) ? WIN_ACT_RESET : D_ZERO;
   endfunction : reg_reset

   // ************************************************************
   // Link receiver and transmitter
   // ************************************************************
   logic sclk_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic [4:0] cnt_q;
   logic [DATA_W-1:0] tx_q;
   logic miso_q;
   logic [DATA_W-1:0] regs_q [REG_COUNT];

   // Edge detect and frame assembly
   wire sclk_rise = link.sclk & ~sclk_q & ~link.cs_n;
   wire sclk_fall = ~link.sclk & sclk_q & ~link.cs_n;
   wire [FRAME_BITS-1:0] frame_w = {rx_q[FRAME_BITS-2:0], link.mosi};
   wire [ADDR_W-1:0] rd_addr = {rx_q[7:0], link.mosi};
   wire rd_load = sclk_rise & (cnt_q == ADDR_DONE_BIT) & ~rx_q[8];
   wire wr_go = sclk_rise & (cnt_q == LAST_BIT) & frame_w[FR_WR];
   wire [ADDR_W-1:0] wr_addr = frame_w[FR_WR-1 -: ADDR_W];
   wire [DATA_W-1:0] wr_data = frame_w[DATA_W-1:0];

   // Bit counter, cleared whenever select is high
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         sclk_q <= 1'b0;
         cnt_q <= 5'h00;
         rx_q <= '0;
      end
      else
      begin
         sclk_q <= link.sclk;
         if (link.cs_n)
            cnt_q <= 5'h00;
         else if (sclk_rise)
         begin
            cnt_q <= cnt_q + 5'h01;
            rx_q <= frame_w;
         end
      end
   end

   // Read data shifted out on falling edges
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         tx_q <= '0;
         miso_q <= 1'b0;
      end
      else if (rd_load)
         tx_q <= (int'(rd_addr) < REG_COUNT) ? regs_q[rd_addr] : D_ZERO;
      else if (sclk_fall)
      begin
         miso_q <= tx_q[DATA_W-1];
         tx_q <= {tx_q[DATA_W-2:0], 1'b0};
      end
   end

   assign link.miso = miso_q;

   // ************************************************************
   // Register file
   // ************************************************************
   // One write port, applied at the last bit of each write frame
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regs_q[i] <= reg_reset(i);
      end
      else if (wr_go && int'(wr_addr) < REG_COUNT)
         regs_q[wr_addr] <= wr_data;
   end

   // ************************************************************
   // Power state
   // ************************************************************
   ssmc_pwr_t pwr_q;
   ssmc_pwr_t pwr_d;
   wire [DATA_W-1:0] mode_w = regs_q[A_MODE];
   wire logic_on = regs_q[A_LOGIC][0];
   wire blocks_on = regs_q[A_CLKGEN][0] & (|regs_q[A_COLMUX]) & regs_q[A_AFE][0] &
                    regs_q[A_BIAS_LO][0] & (|regs_q[A_TX]);

   // State follows the enables, highest loss first
   always_comb
   begin
      pwr_d = PWR_IDLE;
      if (!logic_on)
         pwr_d = PWR_CLK_OFF;
      else if (!blocks_on)
         pwr_d = PWR_STANDBY;
      else if (mode_w[MODE_SEQ_EN])
         pwr_d = PWR_RUNNING;
   end

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   logic [FW-1:0] frm_q;
   logic [FW-1:0] frm_d;
   logic fs_d;
   wire frame_last = (frm_q == FW'(FRAME_CYCLES - 1));

   // Counts frames only while running; stops at once otherwise
   always_comb
   begin
      frm_d = '0;
      fs_d = 1'b0;
      case (pwr_q)
         PWR_RUNNING:
         begin
            frm_d = frame_last ? '0 : frm_q + FW'(1);
            fs_d = (frm_q == '0) && (pwr_d == PWR_RUNNING);
         end
         default:
         begin
            frm_d = '0;
            fs_d = 1'b0;
         end
      endcase
   end

   // Artifact-prone write while running marks the current frame
   wire art_set = wr_go & (pwr_q == PWR_RUNNING) & is_artifact(wr_addr);
   wire art_clr = frame_last | (pwr_q != PWR_RUNNING);

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         pwr_q <= PWR_CLK_OFF;
         frm_q <= '0;
         O_FRAME_START <= 1'b0;
         O_ARTIFACT <= 1'b0;
      end
      else
      begin
         pwr_q <= pwr_d;
         frm_q <= frm_d;
         O_FRAME_START <= fs_d;
         // Set wins over the frame-end clear
         if (art_set)
            O_ARTIFACT <= 1'b1;
         else if (art_clr)
            O_ARTIFACT <= 1'b0;
      end
   end

   // ************************************************************
   // State and mode outputs
   // ************************************************************
   wire global_w = ~mode_w[MODE_ROLLING];

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_STATE <= PWR_CLK_OFF;
         O_CLOCKS_ON <= 1'b0;
         O_BLOCKS_ON <= 1'b0;
         O_ACQUIRING <= 1'b0;
         O_ROLLING <= MODE_RESET[MODE_ROLLING];
         O_ROT_MODE <= MODE_RESET[MODE_ROT_LSB +: 2];
         O_TRIGGERED <= MODE_RESET[MODE_TRIG];
         O_SLAVE <= MODE_RESET[MODE_SLAVE];
      end
      else
      begin
         O_STATE <= pwr_d;
         O_CLOCKS_ON <= (pwr_d != PWR_CLK_OFF);
         O_BLOCKS_ON <= (pwr_d == PWR_IDLE) || (pwr_d == PWR_RUNNING);
         O_ACQUIRING <= (pwr_d == PWR_RUNNING);
         O_ROLLING <= mode_w[MODE_ROLLING];
         O_ROT_MODE <= mode_w[MODE_ROT_LSB +: 2];
         O_TRIGGERED <= mode_w[MODE_TRIG] & global_w;
         O_SLAVE <= mode_w[MODE_SLAVE] & global_w;
      end
   end

   // Frame-synchronous settings: taken at each frame start, and every cycle while not running
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_SUBSAMPLE <= MODE_RESET[MODE_SUBS];
         O_BINNING <= MODE_RESET[MODE_BIN];
         O_WIN_ACTIVE <= {D_ZERO, WIN_ACT_RESET};
         O_GAIN <= D_ZERO;
      end
      else if (fs_d || pwr_q != PWR_RUNNING)
      begin
         O_SUBSAMPLE <= mode_w[MODE_SUBS];
         O_BINNING <= mode_w[MODE_BIN];
         O_WIN_ACTIVE <= {regs_q[A_WIN_ACT_HI], regs_q[A_WIN_ACT_LO]};
         O_GAIN <= regs_q[A_GAIN];
      end
   end

endmodule : ssmc_sensor

// ### core/ssmc_pkg.sv
// Shared constants for the sensor state and mode control pair:
// link framing, sensor register map, mode fields, host register map.
// Assumes both ends run on one common clock.
package ssmc_pkg;

   // ************************************************************
   // Link framing: {write flag, address, data}, MSB first
   // ************************************************************
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int FRAME_BITS = 26;
   localparam int FR_WR = 25;
   localparam logic [4:0] LAST_BIT = 5'h19;
   localparam logic [4:0] ADDR_DONE_BIT = 5'h09;

   // ************************************************************
   // Sensor register map
   // ************************************************************
   localparam logic [8:0] A_CLKGEN = 9'h020;
   localparam logic [8:0] A_LOGIC = 9'h022;
   localparam logic [8:0] A_COLMUX = 9'h028;
   localparam logic [8:0] A_AFE = 9'h030;
   localparam logic [8:0] A_BIAS_LO = 9'h040;
   localparam logic [8:0] A_BIAS_HI = 9'h047;
   localparam logic [8:0] A_TX = 9'h070;
   localparam logic [8:0] A_BLACK_LO = 9'h080;
   localparam logic [8:0] A_SYNC_LO = 9'h081;
   localparam logic [8:0] A_SYNC_HI = 9'h087;
   localparam logic [8:0] A_TEST_LO = 9'h090;
   localparam logic [8:0] A_TEST_HI = 9'h096;
   localparam logic [8:0] A_MODE = 9'h0C0;
   localparam logic [8:0] A_WIN_ACT_LO = 9'h0C3;
   localparam logic [8:0] A_WIN_ACT_HI = 9'h0C4;
   localparam logic [8:0] A_BLACK_LINES = 9'h0C5;
   localparam logic [8:0] A_GAIN = 9'h0CC;
   localparam logic [8:0] A_WIN_FIRST = 9'h100;
   localparam logic [8:0] A_WIN_LAST = 9'h15F;

   // ************************************************************
   // Mode register fields and values
   // ************************************************************
   localparam int MODE_SEQ_EN = 0;
   localparam int MODE_ROLLING = 1;
   localparam int MODE_ROT_LSB = 2;
   localparam int MODE_TRIG = 4;
   localparam int MODE_SLAVE = 5;
   localparam int MODE_SUBS = 7;
   localparam int MODE_BIN = 8;
   localparam int BLACK_LINE_BIT = 8;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] WIN_ACT_RESET = 16'h0001;
   localparam logic [15:0] D_ZERO = 16'h0000;
   localparam logic [15:0] D_CLK_NO_ANALOG = 16'h2002;
   localparam logic [15:0] D_SEQ_NORMAL = 16'h0001;
   localparam logic [15:0] D_SEQ_ZERO = 16'h000D;
   localparam logic [15:0] SEQ_EN_MASK = 16'h0001;

   // ************************************************************
   // Host registers (byte offsets) and actions
   // ************************************************************
   localparam logic [3:0] HO_CTRL = 4'h0;
   localparam logic [3:0] HO_ARG = 4'h4;
   localparam logic [3:0] HO_STATUS = 4'h8;
   localparam logic [3:0] HO_RDATA = 4'hC;
   localparam logic [2:0] ACT_WRITE = 3'h1;
   localparam logic [2:0] ACT_READ = 3'h2;
   localparam logic [2:0] ACT_SEQ_NORMAL = 3'h3;
   localparam logic [2:0] ACT_SEQ_ZERO = 3'h4;
   localparam logic [2:0] ACT_SEQ_OFF = 3'h5;
   localparam logic [2:0] ACT_SOFT_PD = 3'h6;
   localparam logic [2:0] ACT_CLK_OFF = 3'h7;
   localparam logic [2:0] SPD_STEPS = 3'h5;

   typedef enum logic [1:0] {PWR_CLK_OFF, PWR_STANDBY, PWR_IDLE, PWR_RUNNING} ssmc_pwr_t;

   // Registers that must not move while acquiring
   function automatic logic is_static(input logic [8:0] a);
      return (a == A_CLKGEN) || (a == A_COLMUX) || (a == A_AFE) || (a == A_TX) || (a == A_MODE) ||
             ((a >= A_BIAS_LO) && (a <= A_BIAS_HI));
   endfunction : is_static

   // Registers whose change may spoil frames but never stops them
   function automatic logic is_artifact(input logic [8:0] a);
      return ((a >= A_BLACK_LO) && (a <= A_SYNC_HI)) || ((a >= A_TEST_LO) && (a <= A_TEST_HI)) ||
             (a == A_BLACK_LINES);
   endfunction : is_artifact

   // Soft power-down write list
   function automatic logic [24:0] spd_step(input logic [2:0] s);
      case (s)
         3'h0: return {A_TX, D_ZERO};
         3'h1: return {A_AFE, D_ZERO};
         3'h2: return {A_COLMUX, D_ZERO};
         3'h3: return {A_BIAS_LO, D_ZERO};
         default: return {A_CLKGEN, D_CLK_NO_ANALOG};
      endcase
   endfunction : spd_step

endpackage : ssmc_pkg

// ### core/ssmc_link_if.sv
// Serial register link between host controller and sensor.
// Host drives clock, select and data; sensor answers on miso.
`timescale 1ns/1ps
interface ssmc_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;

   modport host (output sclk, output cs_n, output mosi, input miso);
   modport sensor (input sclk, input cs_n, input mosi, output miso);
endinterface : ssmc_link_if

// ### core/ssmc_host.sv
// Host end: AHB-Lite register slave that turns software orders into
// serial register writes and reads on the link.
// Assumes one bus master and a sensor on the same clock.
`timescale 1ns/1ps
module ssmc_host #(
   parameter int HALF_PERIOD = 4
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // AHB-Lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic O_HREADYOUT,
   output logic [31:0] O_HRDATA,
   output logic O_HRESP,
   // Serial register link
   ssmc_link_if.host link
);
   import ssmc_pkg::*;

   localparam int DW = $clog2(HALF_PERIOD);

   if (HALF_PERIOD < 2)
   begin : g_bad_half
      $error("HALF_PERIOD must be at least 2");
   end

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} ssmc_hst_t;

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   logic wr_pend_q;
   logic [3:0] wofs_q;
   logic busy_q;
   logic err_q;
   logic pd_done_q;
   logic [24:0] arg_q;
   logic [15:0] shadow_q;
   logic [15:0] rdata_q;

   wire addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
   wire [31:0] rd_mux = (I_HADDR[3:0] == HO_ARG) ? {7'h00, arg_q} :
                        (I_HADDR[3:0] == HO_STATUS) ? {28'h0000000, pd_done_q, err_q, shadow_q[0], busy_q} :
                        (I_HADDR[3:0] == HO_RDATA) ? {16'h0000, rdata_q} : 32'h00000000;

   // Address phase capture; read data prepared for the data phase
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         wr_pend_q <= 1'b0;
         wofs_q <= 4'h0;
         O_HRDATA <= 32'h00000000;
         O_HREADYOUT <= 1'b0;
         O_HRESP <= 1'b0;
      end
      else
      begin
         wr_pend_q <= addr_ok & I_HWRITE;
         wofs_q <= I_HADDR[3:0];
         O_HRDATA <= (addr_ok && !I_HWRITE) ? rd_mux : 32'h00000000;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end
   end

   // Order decode and legality
   wire [2:0] act_w = I_HWDATA[2:0];
   wire ctrl_wr = wr_pend_q & (wofs_q == HO_CTRL) & ~busy_q;
   wire raw_static = (act_w == ACT_WRITE) & is_static(arg_q[24:16]);
   wire refuse = (raw_static & shadow_q[0]) |
                 ((act_w == ACT_CLK_OFF) & ~pd_done_q) |
                 ((act_w == ACT_SOFT_PD) & shadow_q[0]) |
                 (act_w == 3'h0);
   wire start = ctrl_wr & ~refuse;

   // Link word for an action step
   function automatic logic [FRAME_BITS-1:0] host_word(input logic [2:0] act, input logic [2:0] s);
      logic [24:0] ad;
      logic w;
      ad = arg_q;
      w = 1'b1;
      case (act)
         ACT_READ: w = 1'b0;
         ACT_SEQ_NORMAL: ad = {A_MODE, D_SEQ_NORMAL};
         ACT_SEQ_ZERO: ad = {A_MODE, D_SEQ_ZERO};
         ACT_SEQ_OFF: ad = {A_MODE, shadow_q & ~SEQ_EN_MASK};
         ACT_SOFT_PD: ad = spd_step(s);
         ACT_CLK_OFF: ad = {A_LOGIC, D_ZERO};
         default: ad = arg_q;
      endcase
      return {w, ad};
   endfunction : host_word

   // ************************************************************
   // Link engine
   // ************************************************************
   ssmc_hst_t st_q;
   logic [2:0] act_q;
   logic [2:0] step_q;
   logic [DW-1:0] div_q;
   logic [4:0] bit_q;
   logic [FRAME_BITS-1:0] sh_q;
   logic [15:0] rx_q;
   logic sclk_q;
   logic cs_n_q;
   logic mosi_q;

   wire tick = (div_q == DW'(HALF_PERIOD - 1));
   wire [2:0] steps = (act_q == ACT_SOFT_PD) ? SPD_STEPS : 3'h1;
   wire [FRAME_BITS-1:0] next_word = host_word(act_q, step_q + 3'h1);
   wire [FRAME_BITS-1:0] first_word = host_word(act_w, 3'h0);

   // Software state: arguments, shadow of the mode register, flags
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         arg_q <= 25'h0000000;
         shadow_q <= MODE_RESET;
         err_q <= 1'b0;
         pd_done_q <= 1'b0;
      end
      else
      begin
         if (wr_pend_q && wofs_q == HO_ARG)
            arg_q <= I_HWDATA[24:0];
         if (ctrl_wr)
            err_q <= refuse;
         if (start && first_word[FR_WR] && first_word[24:16] == A_MODE)
            shadow_q <= first_word[15:0];
         if (start && act_w == ACT_SOFT_PD)
            pd_done_q <= 1'b1;
         else if (start && act_w == ACT_WRITE && arg_q[24:16] == A_CLKGEN)
            pd_done_q <= 1'b0;
      end
   end

   // Frame shifter: mosi changes on falling sclk, miso taken on rising
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         st_q <= H_IDLE;
         act_q <= 3'h0;
         step_q <= 3'h0;
         div_q <= '0;
         bit_q <= 5'h00;
         sh_q <= '0;
         rx_q <= 16'h0000;
         rdata_q <= 16'h0000;
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
      end
      else
      begin
         div_q <= (st_q == H_IDLE || tick) ? '0 : div_q + DW'(1);
         case (st_q)
            H_IDLE:
               if (start)
               begin
                  act_q <= act_w;
                  step_q <= 3'h0;
                  sh_q <= first_word;
                  mosi_q <= first_word[FR_WR];
                  bit_q <= 5'h00;
                  cs_n_q <= 1'b0;
                  busy_q <= 1'b1;
                  st_q <= H_LOW;
               end
            H_LOW:
               if (tick)
               begin
                  sclk_q <= 1'b1;
                  rx_q <= {rx_q[14:0], link.miso};
                  st_q <= H_HIGH;
               end
            H_HIGH:
               if (tick)
               begin
                  sclk_q <= 1'b0;
                  sh_q <= {sh_q[FRAME_BITS-2:0], 1'b0};
                  mosi_q <= sh_q[FRAME_BITS-2];
                  bit_q <= bit_q + 5'h01;
                  cs_n_q <= (bit_q == LAST_BIT);
                  st_q <= (bit_q == LAST_BIT) ? H_GAP : H_LOW;
               end
            H_GAP:
               if (tick)
               begin
                  // Steps go out strictly one after another
                  if (step_q + 3'h1 == steps)
                  begin
                     busy_q <= 1'b0;
                     if (act_q == ACT_READ)
                        rdata_q <= rx_q;
                     st_q <= H_IDLE;
                  end
                  else
                  begin
                     step_q <= step_q + 3'h1;
                     sh_q <= next_word;
                     mosi_q <= next_word[FR_WR];
                     bit_q <= 5'h00;
                     cs_n_q <= 1'b0;
                     st_q <= H_LOW;
                  end
               end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = mosi_q;

endmodule : ssmc_host

// ### dv/ssmc_link_asserts.sv
// Checker for serial frames between the host and sensor ends.
// Assumes link clock half periods stand four clock cycles each.
`timescale 1ns/1ps
module ssmc_link_asserts (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // Link signals
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic sclk_q;
   logic [5:0] rise_q;
   logic [5:0] rise_d;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // Count link clock rises in a frame
   assign rise_d = cs_n ? 6'h00 : rise_q + {5'h00, sclk & ~sclk_q};
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         sclk_q <= 1'b0;
         rise_q <= 6'h00;
      end
      else
      begin
         sclk_q <= sclk;
         rise_q <= rise_d;
      end
   end
   // ***************
   // Properties
   // ***************
   property p_idle_low; cs_n |-> !sclk; endproperty
   property p_high_len; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
   property p_low_len; $fell(sclk) && !cs_n |-> !sclk [*4] ##1 sclk; endproperty
   property p_gap_len; $rose(cs_n) |-> cs_n [*4]; endproperty
   property p_frame_len; $fell(cs_n) |-> ##208 $rose(cs_n); endproperty
   property p_mosi_hold; sclk |-> $stable(mosi); endproperty
   property p_miso_hold; sclk |-> $stable(miso); endproperty
   property p_rise_cnt; $rose(cs_n) |-> rise_q == 6'h1A; endproperty
   a_idle_low:
      assert property (p_idle_low) else $error("link clock moves outside a frame");
   a_high_len:
      assert property (p_high_len) else $error("link clock high phase wrong");
   a_low_len:
      assert property (p_low_len) else $error("link clock low phase wrong");
   a_gap_len:
      assert property (p_gap_len) else $error("gap between frames too short");
   a_frame_len:
      assert property (p_frame_len) else $error("frame length wrong");
   a_mosi_hold:
      assert property (p_mosi_hold) else $error("host data moved while clock high");
   a_miso_hold:
      assert property (p_miso_hold) else $error("sensor data moved while clock high");
   a_rise_cnt:
      assert property (p_rise_cnt) else $error("frame without 26 clock rises");
   // Main link activity
   c_frame: cover property ($rose(cs_n));
   c_miso: cover property ($rose(miso));
   c_zero: cover property (sclk && !mosi);
endmodule : ssmc_link_asserts

// ### dv/sensor_state_mode_control_tb.sv
// Bench: AHB-Lite master drives the host end, which talks to the sensor.
// Assumes a zero-wait slave and 16-cycle frames in simulation.
`timescale 1ns/1ps
module sensor_state_mode_control_tb;
   import ssmc_pkg::*;
   logic clk, rst_n, hsel, hwrite, hready, clk_on, blk_on, acq, fst, roll, trig, slv;
   logic hresp, sub, bin, art, art_seen;
   logic [1:0] htrans, readout_overhead_time;
   logic [31:0] haddr, hwdata, hrdata, win, q;
   logic [15:0] gain;
   ssmc_pwr_t st;
   int error_cnt = 0;
   int compares = 0;
   ssmc_link_if link ();
   ssmc_host #(.HALF_PERIOD(4)) ssmc_host_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp), .link(link.host));
   ssmc_sensor #(.FRAME_CYCLES(16)) ssmc_sensor_inst (.I_CLK(clk), .I_RST_N(rst_n), .link(link.sensor),
      .O_STATE(st), .O_CLOCKS_ON(clk_on), .O_BLOCKS_ON(blk_on), .O_ACQUIRING(acq), .O_FRAME_START(fst),
      .O_ARTIFACT(art), .O_ROLLING(roll), .O_ROT_MODE(readout_overhead_time), .O_TRIGGERED(trig), .O_SLAVE(slv),
      .O_SUBSAMPLE(sub), .O_BINNING(bin), .O_WIN_ACTIVE(win), .O_GAIN(gain));
   ssmc_link_asserts ssmc_link_asserts_inst (.I_CLK(clk), .I_RST_N(rst_n), .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
   // Sticky artifact mark
   always @(posedge clk) art_seen <= rst_n & (art_seen | art);
   // ***************
   // Helpers
   // ***************
   task automatic complete_run;
      $display("compares=%0d mismatches=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic tmo;
      error_cnt++;
      $display("MISMATCH t=%0t wait ran out", $time);
      complete_run;
   endtask : tmo
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Wait for ready, or for a frame start
   task automatic wt(input logic frame);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while ((frame ? fst : hready) !== 1'b1 && n < 100);
      if ((frame ? fst : hready) !== 1'b1) tmo;
   endtask : wt
   // One single AHB-Lite word transfer
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {28'h0, a};
      wt(1'b0);
      htrans <= 2'h0;
      hwdata <= d;
      wt(1'b0);
      q = hrdata;
   endtask : bus
   // One host action, then poll until idle
   task automatic act(input logic [2:0] c, input logic [8:0] a, input logic [15:0] d);
      int n;
      n = 0;
      bus(1'b1, HO_ARG, {7'h00, a, d});
      bus(1'b1, HO_CTRL, {29'h0, c});
      do
      begin
         bus(1'b0, HO_STATUS, 32'h0);
         n++;
      end
      while (q[0] !== 1'b0 && n < 900);
      if (q[0] !== 1'b0) tmo;
   endtask : act
   // ***************
   // Scenarios
   // ***************
   task automatic t_up;
      chk(win, 32'h1);
      act(ACT_WRITE, A_LOGIC, 16'h0001);
      act(ACT_CLK_OFF, 9'h0, 16'h0);
      chk({29'h0, q[2], clk_on, st == PWR_STANDBY}, 32'h7);
      act(ACT_WRITE, A_CLKGEN, 16'h2003);
      act(ACT_WRITE, A_BIAS_LO, 16'h0001);
      act(ACT_WRITE, A_COLMUX, 16'h0003);
      act(ACT_WRITE, A_AFE, 16'h0001);
      act(ACT_WRITE, A_TX, 16'h0007);
      chk({29'h0, st == PWR_IDLE, blk_on, acq}, 32'h6);
      $display("test power-up done");
   endtask : t_up
   task automatic t_run;
      act(ACT_SEQ_ZERO, 9'h0, 16'h0);
      chk({28'h0, acq, st == PWR_RUNNING, readout_overhead_time}, 32'hF);
      act(ACT_WRITE, A_GAIN, 16'h09E6);
      act(ACT_WRITE, A_WIN_ACT_LO, 16'h0005);
      wt(1'b1);
      wt(1'b1);
      chk({gain, win[15:0]}, 32'h09E60005);
      act(ACT_WRITE, A_BLACK_LO, 16'h0001);
      chk({30'h0, art_seen, acq}, 32'h3);
      act(ACT_READ, A_GAIN, 16'h0000);
      bus(1'b0, HO_RDATA, 32'h0);
      chk({hresp, q[30:0]}, 32'h9E6);
      act(ACT_SEQ_OFF, 9'h0, 16'h0);
      chk({28'h0, acq, st == PWR_IDLE, readout_overhead_time}, 32'h7);
      $display("test run and stop done");
   endtask : t_run
   task automatic t_mode;
      act(ACT_WRITE, A_MODE, 16'h01B2);
      chk({27'h0, sub, bin, roll, trig, slv}, 32'h1C);
      act(ACT_WRITE, A_MODE, 16'h0030);
      chk({27'h0, sub, bin, roll, trig, slv}, 32'h3);
      act(ACT_SEQ_NORMAL, 9'h0, 16'h0);
      act(ACT_WRITE, A_AFE, 16'h0000);
      chk({28'h0, acq, readout_overhead_time, q[2]}, 32'h9);
      act(ACT_SEQ_OFF, 9'h0, 16'h0);
      $display("test mode fields done");
   endtask : t_mode
   task automatic t_down;
      act(ACT_SOFT_PD, 9'h0, 16'h0);
      bus(1'b0, HO_STATUS, 32'h0);
      chk({29'h0, q[3], st == PWR_STANDBY, blk_on}, 32'h6);
      act(ACT_CLK_OFF, 9'h0, 16'h0);
      chk({30'h0, st == PWR_CLK_OFF, clk_on}, 32'h2);
      $display("test power-down done");
   endtask : t_down
   // Clock of 4 ns
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Reset, then the scenarios
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_up;
      t_run;
      t_mode;
      t_down;
      complete_run;
   end
endmodule : sensor_state_mode_control_tb
